/* rtl/pwc_core.sv */
// Notes on behaviour
// - Capture command stores current angle as reference
// - Reference and settings kept on low-power rail
// - Compare angle with reference after 250 us
// - Wake when difference exceeds programmed threshold
// - On-time counted from power-on reset release
// - Gain code zero means field too strong
// - Gain code 63 means field too weak
// - Wake pulls low about 10 us, then releases
// - Retained copy only with wake-enable fuse set
`timescale 1ns/1ps
`default_nettype none
module pwc_core (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic       keep_resetn_i,
    input  wire logic [7:0] angle_i,
    input  wire logic       angle_locked_i,
    input  wire logic [5:0] agc_i,
    input  wire logic       wake_fuse_i,
    input  wire logic       cmd_valid_i,
    input  wire logic [4:0] cmd_i,
    input  wire logic [7:0] cmd_data_i,
    output logic            trim_reload_o,
    output logic            field_strong_o,
    output logic            field_weak_o,
    output logic            compare_done_o,
    output logic [7:0]      angle_diff_o,
    output logic            wake_o,
    output logic            wake_oe_o
);
    pwc_retain_if rif ();

    pwc_retain u_retain (
        .clock_i       (clock_i),
        .keep_resetn_i (keep_resetn_i),
        .bus           (rif.retain)
    );

    // Shortest distance on the circle
    function automatic logic [7:0] circ_dist(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        circ_dist = d[7] ? (8'h00 - d) : d;
    endfunction

    // Command decode; retained writes only with fuse set
    logic is_cap;
    logic is_cust;
    assign is_cap  = cmd_valid_i && (cmd_i == pwc_pkg::CMD_CAPTURE_REF);
    assign is_cust = cmd_valid_i && (cmd_i == pwc_pkg::CMD_CUST_WRITE);
    assign rif.wr_ref    = is_cap && wake_fuse_i;
    assign rif.wr_valid  = is_cap && wake_fuse_i;
    assign rif.wr_thresh = is_cust && wake_fuse_i;
    assign rif.wdata     = is_cap ? angle_i : cmd_data_i;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trim_reload_o <= 1'b0;
        end else begin
            trim_reload_o <= cmd_valid_i && (cmd_i == pwc_pkg::CMD_TRIM_RELOAD);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            field_strong_o <= 1'b0;
            field_weak_o   <= 1'b0;
        end else begin
            field_strong_o <= (agc_i == pwc_pkg::AGC_STRONG);
            field_weak_o   <= (agc_i == pwc_pkg::AGC_WEAK);
        end
    end

    pwc_pkg::pwc_state_t state;
    pwc_pkg::pwc_state_t next_state;
    logic [13:0] cnt;
    logic [7:0]  diff;
    logic        exceed;
    assign diff   = circ_dist(angle_i, rif.ref_angle);
    assign exceed = !rif.ref_valid || (diff > rif.thresh);

    always_comb begin
        next_state = state;
        case (state)
            pwc_pkg::PWC_WAIT_ON: begin
                if (cnt == 14'(pwc_pkg::ON_CYC - 1)) begin
                    next_state = pwc_pkg::PWC_COMPARE;
                end
            end
            pwc_pkg::PWC_COMPARE: begin
                next_state = exceed ? pwc_pkg::PWC_WAKE : pwc_pkg::PWC_IDLE;
            end
            pwc_pkg::PWC_WAKE: begin
                if (cnt == 14'(pwc_pkg::WAKE_CYC - 1)) begin
                    next_state = pwc_pkg::PWC_IDLE;
                end
            end
            pwc_pkg::PWC_IDLE: next_state = pwc_pkg::PWC_IDLE;
            default: next_state = pwc_pkg::PWC_IDLE;
        endcase
    end

    // Power-on reset release starts the on-time count
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= pwc_pkg::PWC_WAIT_ON;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 14'h0000;
        end else if (next_state != state) begin
            cnt <= 14'h0000;
        end else if (state == pwc_pkg::PWC_WAIT_ON || state == pwc_pkg::PWC_WAKE) begin
            cnt <= cnt + 14'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            compare_done_o <= 1'b0;
            angle_diff_o   <= 8'h00;
        end else if (state == pwc_pkg::PWC_COMPARE) begin
            compare_done_o <= 1'b1;
            angle_diff_o   <= diff;
        end
    end

    // Open drain: only ever pulls low
    assign wake_o    = 1'b0;
    assign wake_oe_o = (state == pwc_pkg::PWC_WAKE);

    // Pulse length kept in a counter: too long for a plain delay
    logic [8:0] wake_run;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_run <= 9'h000;
        end else if (wake_oe_o) begin
            wake_run <= wake_run + 9'h001;
        end else begin
            wake_run <= 9'h000;
        end
    end

    property p_wait_on;
        @(posedge clock_i) disable iff (!resetn_i)
        $rose(state == pwc_pkg::PWC_COMPARE) |-> $past(cnt) == 14'(pwc_pkg::ON_CYC - 1);
    endproperty
    a_wait_on: assert property (p_wait_on) else $error("compare before on-time");

    property p_wake_len;
        @(posedge clock_i) disable iff (!resetn_i)
        $fell(wake_oe_o) |-> wake_run == 9'(pwc_pkg::WAKE_CYC);
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake pulse length wrong");

    property p_wake_max;
        @(posedge clock_i) disable iff (!resetn_i)
        wake_oe_o |-> wake_run < 9'(pwc_pkg::WAKE_CYC);
    endproperty
    a_wake_max: assert property (p_wake_max) else $error("wake pulse too long");

    property p_wake_cause;
        @(posedge clock_i) disable iff (!resetn_i)
        (state == pwc_pkg::PWC_COMPARE) |=> (wake_oe_o == $past(exceed));
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake not tied to compare");

    property p_no_wake_early;
        @(posedge clock_i) disable iff (!resetn_i)
        (state == pwc_pkg::PWC_WAIT_ON) |-> !wake_oe_o;
    endproperty
    a_no_wake_early: assert property (p_no_wake_early) else $error("wake during on-time");

    property p_fuse_gate;
        @(posedge clock_i) disable iff (!resetn_i || !keep_resetn_i)
        (is_cap && !wake_fuse_i) |=> $stable(rif.ref_angle) && $stable(rif.ref_valid);
    endproperty
    a_fuse_gate: assert property (p_fuse_gate) else $error("copy without fuse");

    property p_capture;
        @(posedge clock_i) disable iff (!resetn_i || !keep_resetn_i)
        (is_cap && wake_fuse_i) |=> (rif.ref_angle == $past(angle_i)) && rif.ref_valid;
    endproperty
    a_capture: assert property (p_capture) else $error("reference not captured");

    property p_dist;
        @(posedge clock_i) disable iff (!resetn_i)
        diff <= 8'h80;
    endproperty
    a_dist: assert property (p_dist) else $error("distance not shortest");

    property p_agc;
        @(posedge clock_i) disable iff (!resetn_i)
        (agc_i == pwc_pkg::AGC_WEAK) |=> field_weak_o && !field_strong_o;
    endproperty
    a_agc: assert property (p_agc) else $error("weak field flag wrong");

    property p_trim;
        @(posedge clock_i) disable iff (!resetn_i)
        (cmd_valid_i && cmd_i == pwc_pkg::CMD_TRIM_RELOAD) |=> trim_reload_o;
    endproperty
    a_trim: assert property (p_trim) else $error("trim reload pulse missing");

    property p_one_compare;
        @(posedge clock_i) disable iff (!resetn_i)
        compare_done_o |-> (state != pwc_pkg::PWC_COMPARE);
    endproperty
    a_one_compare: assert property (p_one_compare) else $error("second compare");

    property p_thresh;
        @(posedge clock_i) disable iff (!resetn_i || !keep_resetn_i)
        (is_cust && wake_fuse_i) |=> (rif.thresh == $past(cmd_data_i));
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold not written");

    c_wake:   cover property (@(posedge clock_i) $rose(wake_oe_o));
    c_quiet:  cover property (@(posedge clock_i) state == pwc_pkg::PWC_COMPARE && !exceed);
    c_cap:    cover property (@(posedge clock_i) rif.wr_ref);
    c_thresh: cover property (@(posedge clock_i) rif.wr_thresh);
endmodule : pwc_core
`default_nettype wire

/* rtl/pwc_pkg.sv */
package pwc_pkg;
    localparam int unsigned CLK_HZ             = 40_000_000;
    localparam int unsigned ANGLE_W            = 8;
    localparam int unsigned AGC_W              = 6;
    localparam int unsigned CMD_W              = 5;
    // On-time before compare, microseconds (cycles per microsecond: rounds down)
    localparam int unsigned T_ON_US            = 250;
    localparam int unsigned ON_CYC             = (T_ON_US * (CLK_HZ / 1_000_000));
    // Wake pulse, microseconds (cycles per microsecond: rounds down)
    localparam int unsigned T_WAKE_US          = 10;
    localparam int unsigned WAKE_CYC           = (T_WAKE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned CNT_W              = 14;
    localparam logic [4:0]  CMD_TRIM_RELOAD    = 5'h13;
    localparam logic [4:0]  CMD_CAPTURE_REF    = 5'h03;
    localparam logic [4:0]  CMD_CUST_WRITE     = 5'h1F;
    localparam logic [5:0]  AGC_STRONG         = 6'h00;
    localparam logic [5:0]  AGC_WEAK           = 6'h3F;
    localparam logic [7:0]  REF_RESET          = 8'h00;
    localparam logic [7:0]  THRESH_RESET       = 8'h00;

    typedef enum logic [1:0] {
        PWC_WAIT_ON,
        PWC_COMPARE,
        PWC_WAKE,
        PWC_IDLE
    } pwc_state_t;
endpackage : pwc_pkg

/* rtl/pwc_retain_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Signals between the core and the retained register bank
interface pwc_retain_if;
    logic       wr_ref;
    logic       wr_thresh;
    logic       wr_valid;
    logic [7:0] wdata;
    logic [7:0] ref_angle;
    logic [7:0] thresh;
    logic       ref_valid;
    modport core   (output wr_ref, output wr_thresh, output wr_valid, output wdata,
                    input ref_angle, input thresh, input ref_valid);
    modport retain (input wr_ref, input wr_thresh, input wr_valid, input wdata,
                    output ref_angle, output thresh, output ref_valid);
endinterface : pwc_retain_if
`default_nettype wire

/* rtl/pwc_retain.sv */
`timescale 1ns/1ps
`default_nettype none
// Bank kept alive by the low-power rail; its reset is the rail's own
module pwc_retain (
    input  wire logic   clock_i,
    input  wire logic   keep_resetn_i,
    pwc_retain_if.retain bus
);
    always_ff @(posedge clock_i or negedge keep_resetn_i) begin
        if (!keep_resetn_i) begin
            bus.ref_angle <= pwc_pkg::REF_RESET;
        end else if (bus.wr_ref) begin
            bus.ref_angle <= bus.wdata;
        end
    end

    always_ff @(posedge clock_i or negedge keep_resetn_i) begin
        if (!keep_resetn_i) begin
            bus.thresh <= pwc_pkg::THRESH_RESET;
        end else if (bus.wr_thresh) begin
            bus.thresh <= bus.wdata;
        end
    end

    always_ff @(posedge clock_i or negedge keep_resetn_i) begin
        if (!keep_resetn_i) begin
            bus.ref_valid <= 1'b0;
        end else if (bus.wr_valid) begin
            bus.ref_valid <= 1'b1;
        end
    end
endmodule : pwc_retain
`default_nettype wire

/* dv/pwc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the wake line: the board pull-up wins whenever nobody pulls low
module pwc_host (
    input  wire logic wake_i,
    input  wire logic wake_oe_i,
    output var  logic wake_n_o
);
    always_comb begin
        wake_n_o = wake_oe_i ? wake_i : 1'b1;
    end
endmodule // pwc_host
`default_nettype wire

/* dv/test_polling_wake_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module test_polling_wake_compare;
    logic       clock_i, resetn_i, keep_resetn_i, angle_locked_i, wake_fuse_i;
    logic       cmd_valid_i, trim_reload_o, field_strong_o, field_weak_o;
    logic       compare_done_o, wake_o, wake_oe_o, wake_n;
    logic [7:0] angle_i, cmd_data_i, angle_diff_o;
    logic [5:0] agc_i;
    logic [4:0] cmd_i;
    integer     fails = 0;
    integer     compares = 0;

    pwc_core u_pwc_core (.clock_i(clock_i), .resetn_i(resetn_i), .keep_resetn_i(keep_resetn_i),
        .angle_i(angle_i), .angle_locked_i(angle_locked_i), .agc_i(agc_i),
        .wake_fuse_i(wake_fuse_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .cmd_data_i(cmd_data_i), .trim_reload_o(trim_reload_o),
        .field_strong_o(field_strong_o), .field_weak_o(field_weak_o),
        .compare_done_o(compare_done_o), .angle_diff_o(angle_diff_o),
        .wake_o(wake_o), .wake_oe_o(wake_oe_o));
    pwc_host u_pwc_host (.wake_i(wake_o), .wake_oe_i(wake_oe_o), .wake_n_o(wake_n));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic send(input logic [4:0] c, input logic [7:0] d);
        integer k;
        integer hi;
        hi = 0;
        @(posedge clock_i);
        cmd_valid_i <= 1'b1;
        cmd_i       <= c;
        cmd_data_i  <= d;
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
        for (k = 0; k < 3; k++) begin
            #1 hi += trim_reload_o;
            @(posedge clock_i);
        end
        check("trim_pulses", hi, (c == pwc_pkg::CMD_TRIM_RELOAD) ? 1 : 0);
    endtask

    // One supply pulse; the on-phase outlasts the compare and the wake pulse
    task automatic power(input logic [7:0] ang, input logic exp_wake, input logic [7:0] exp_diff,
                         input logic chk_diff);
        integer n;
        integer w;
        n = 0;
        w = 0;
        @(posedge clock_i);
        resetn_i <= 1'b0;
        // Magnet held still per pulse, so one sample suffices
        angle_i  <= ang;
        @(posedge clock_i);
        resetn_i <= 1'b1;
        do begin
            @(posedge clock_i);
            #1 n++;
        end while (compare_done_o !== 1'b1 && n < 10100);
        check("on_time", n, pwc_pkg::ON_CYC + 1);
        while (wake_n === 1'b0 && w < 500) begin
            @(posedge clock_i);
            #1 w++;
        end
        check("wake_cycles", w, exp_wake ? pwc_pkg::WAKE_CYC : 0);
        check("wake_data", wake_o, 0);
        if (chk_diff) check("angle_diff", angle_diff_o, exp_diff);
    endtask

    task automatic agc_levels();
        agc_i <= pwc_pkg::AGC_STRONG;
        repeat (2) @(posedge clock_i);
        #1 check("strong", {field_strong_o, field_weak_o}, 2'b10);
        agc_i <= pwc_pkg::AGC_WEAK;
        repeat (2) @(posedge clock_i);
        #1 check("weak", {field_strong_o, field_weak_o}, 2'b01);
        agc_i <= 6'h1_8;
        repeat (2) @(posedge clock_i);
        #1 check("mid", {field_strong_o, field_weak_o}, 2'b00);
    endtask

    initial begin
        resetn_i = 1'b0;
        keep_resetn_i = 1'b0;
        angle_locked_i = 1'b1;
        wake_fuse_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_i = 5'h0_0;
        cmd_data_i = 8'h0_0;
        angle_i = 8'h1_0;
        agc_i = 6'h1_8;
        repeat (5) @(posedge clock_i);
        keep_resetn_i <= 1'b1;
        // Warm-up shortened: the core does not time it
        resetn_i <= 1'b1;
        power(8'h1_0, 1'b1, 8'h0_0, 1'b0);
        send(pwc_pkg::CMD_TRIM_RELOAD, 8'h0_0);
        send(pwc_pkg::CMD_CAPTURE_REF, 8'h0_0);
        send(pwc_pkg::CMD_CUST_WRITE, 8'h0_5);
        power(8'h1_5, 1'b0, 8'h0_5, 1'b1);
        power(8'h1_6, 1'b1, 8'h0_6, 1'b1);
        power(8'hF_E, 1'b1, 8'h1_2, 1'b1);
        wake_fuse_i <= 1'b0;
        angle_i <= 8'h8_0;
        send(pwc_pkg::CMD_CAPTURE_REF, 8'h0_0);
        power(8'h1_0, 1'b0, 8'h0_0, 1'b1);
        agc_levels();
        report_and_stop();
    end

    initial begin
        #(25 * 70000);
        fails++;
        report_and_stop();
    end
endmodule // test_polling_wake_compare
`default_nettype wire
